// *** verilog/dmx_params.svh ***
// constants for the data-move execute block
`ifndef DMX_PARAMS_SVH
`define DMX_PARAMS_SVH
`define DMX_OPC_SRC      4'hC
`define DMX_OPC_DST      4'hF
`define DMX_OPC_BANK     8'h01
`define DMX_OPC_ACCLIT   8'h0E
`define DMX_BANK_MASK    8'h0F
`define DMX_ADDR_ACC     12'hFE8
`define DMX_ADDR_PCL     12'hFF9
`define DMX_ADDR_STACK_TOP_LOW_BYTE    12'hFFD
`define DMX_ADDR_STACK_TOP_HIGH_BYTE    12'hFFE
`define DMX_ADDR_STACK_TOP_UPPER_BYTE    12'hFFF
`define DMX_Q1           4'h1
`define DMX_Q2           4'h2
`define DMX_Q3           4'h4
`define DMX_Q4           4'h8
`define DMX_RST_BYTE     8'h00
`define DMX_RST_ADDR     12'h000
`endif

// *** verilog/dmx_pkg.sv ***
// types for the data-move execute block
package dmx_pkg;
  typedef logic [15:0] dmx_word_t;
  typedef logic [11:0] dmx_addr_t;
  typedef logic [7:0]  dmx_byte_t;
  typedef logic [3:0]  dmx_phase_t;
  typedef enum logic [2:0] {
    DMX_IDLE = 3'b001,
    DMX_DST  = 3'b010,
    DMX_WR   = 3'b100
  } dmx_state_e;
endpackage

// *** verilog/dmx_phase_gen.sv ***
// four-phase generator of the instruction cycle
`timescale 1ns/1ps
`include "dmx_params.svh"
module dmx_phase_gen (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // phase
  output dmx_pkg::dmx_phase_t phase
);
  import dmx_pkg::*;
  typedef struct packed {
    dmx_phase_t ph;
  } dmx_pg_s;
  dmx_pg_s st_r;
  dmx_pg_s st_nxt;
  always_comb begin
    st_nxt    = st_r;
    st_nxt.ph = {st_r.ph[2:0], st_r.ph[3]};
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.ph <= `DMX_Q1;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign phase = st_r.ph;
endmodule

// *** verilog/dmx_exec.sv ***
// decode and execute of the three data-move instructions
`timescale 1ns/1ps
`include "dmx_params.svh"
// Operation
// (RULE1) The copy takes a 12-bit source from a word opcode 1100 and destination from opcode 1111.
// (RULE2) The working accumulator is an ordinary source or destination of the copy.
// (RULE3) Software must not name program counter low or any stack top byte as copy destination.
// (RULE4) The bank load with opcode 0000 0001 writes its literal to the bank register in one cycle.
// (RULE5) The bank load forces the upper four bits of the bank register to zero.
// (RULE6) The accumulator load with opcode 0000 1110 writes its literal to the accumulator.
// (RULE7) The copy takes two cycles, reading at phase two of the first and writing at phase four.
module dmx_exec (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // instruction from fetch
  input  wire dmx_pkg::dmx_word_t instr_word,
  input  wire logic              instr_valid,
  // data memory
  output dmx_pkg::dmx_addr_t     mem_addr,
  output logic                   mem_rd,
  input  wire dmx_pkg::dmx_byte_t mem_rdata,
  output logic                   mem_wr,
  output dmx_pkg::dmx_byte_t     mem_wdata,
  // core state
  output dmx_pkg::dmx_byte_t     bank_selection_register,
  output dmx_pkg::dmx_byte_t     accumulator,
  output dmx_pkg::dmx_phase_t    phase,
  output logic                   busy,
  output logic                   bad_dest
);
  import dmx_pkg::*;
  typedef struct packed {
    dmx_state_e st;
    dmx_addr_t  addr;
    dmx_byte_t  data;
    logic       rd;
    logic       wr;
    dmx_byte_t  bank;
    dmx_byte_t  acc;
    logic       bad;
  } dmx_ex_s;
  dmx_ex_s s_r;
  dmx_ex_s s_nxt;
  dmx_phase_t ph;
  dmx_addr_t  arg;
  dmx_byte_t  lit;
  // ----------------------------------------
  // phase generator
  // ----------------------------------------
  dmx_phase_gen u_phase (
    .clock   (clock),
    .sys_rst (sys_rst),
    .phase   (ph)
  );
  assign arg = instr_word[11:0];
  assign lit = instr_word[7:0];
  // ----------------------------------------
  // decode and execute
  // ----------------------------------------
  always_comb begin
    s_nxt    = s_r;
    s_nxt.rd = 1'b0;
    s_nxt.wr = 1'b0;
    case (s_r.st)
      DMX_IDLE: begin
        if (instr_valid && ph == `DMX_Q1) begin
          if (instr_word[15:12] == `DMX_OPC_SRC) begin
            s_nxt.addr = arg; // [RULE1]
            s_nxt.rd   = 1'b1; // [RULE7]
            s_nxt.st   = DMX_DST;
          end else if (instr_word[15:8] == `DMX_OPC_BANK) begin
            s_nxt.bank = lit & `DMX_BANK_MASK; // [RULE4] [RULE5]
          end else if (instr_word[15:8] == `DMX_OPC_ACCLIT) begin
            s_nxt.acc = lit; // [RULE6]
          end
        end
      end
      DMX_DST: begin
        if (s_r.rd) begin
          s_nxt.data = (s_r.addr == `DMX_ADDR_ACC) ? s_r.acc : mem_rdata; // [RULE2]
        end
        if (instr_valid && ph == `DMX_Q1 && instr_word[15:12] == `DMX_OPC_DST) begin
          s_nxt.addr = arg; // [RULE1]
          s_nxt.bad  = (arg == `DMX_ADDR_PCL) || (arg == `DMX_ADDR_STACK_TOP_LOW_BYTE) ||
                       (arg == `DMX_ADDR_STACK_TOP_HIGH_BYTE) || (arg == `DMX_ADDR_STACK_TOP_UPPER_BYTE); // [RULE3]
          s_nxt.st   = DMX_WR;
        end
      end
      DMX_WR: begin
        if (ph == `DMX_Q3) begin
          if (s_r.addr == `DMX_ADDR_ACC) begin
            s_nxt.acc = s_r.data; // [RULE2]
          end else begin
            s_nxt.wr = ~s_r.bad; // [RULE7]
          end
          s_nxt.st = DMX_IDLE;
        end
      end
      default: begin
        s_nxt.st = DMX_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_r.st   <= DMX_IDLE;
      s_r.addr <= `DMX_RST_ADDR;
      s_r.data <= `DMX_RST_BYTE;
      s_r.rd   <= 1'b0;
      s_r.wr   <= 1'b0;
      s_r.bank <= `DMX_RST_BYTE;
      s_r.acc  <= `DMX_RST_BYTE;
      s_r.bad  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign mem_addr                = s_r.addr;
  assign mem_rd                  = s_r.rd;
  assign mem_wr                  = s_r.wr;
  assign mem_wdata               = s_r.data;
  assign bank_selection_register = s_r.bank;
  assign accumulator             = s_r.acc;
  assign phase                   = ph;
  assign busy                    = s_r.st != DMX_IDLE;
  assign bad_dest                = s_r.bad;
endmodule

// *** testbench/dmx_exec_asserts.sv ***
// assertions of the data-move execute block
`timescale 1ns/1ps
module dmx_exec_asserts (
  input logic        clock,
  input logic        sys_rst,
  input logic [15:0] instr_word,
  input logic        instr_valid,
  input logic [11:0] mem_addr,
  input logic        mem_rd,
  input logic        mem_wr,
  input logic [7:0]  bank_selection_register,
  input logic [7:0]  accumulator,
  input logic [3:0]  phase,
  input logic        busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire        tk    = phase == 4'h1 && instr_valid;
  wire        itk   = tk && !busy;
  wire [7:0]  opc   = instr_word[15:8];
  wire [3:0]  nib   = instr_word[15:12];
  wire [11:0] fa    = instr_word[11:0];
  wire [7:0]  kb    = {4'h0, instr_word[3:0]};
  wire [7:0]  lit   = instr_word[7:0];
  wire        plain = fa != 12'hFE8 && fa != 12'hFF9 && fa != 12'hFFD &&
                      fa != 12'hFFE && fa != 12'hFFF;
  sequence src_s; itk && nib == 4'hC; endsequence
  sequence dst_s; tk && busy && nib == 4'hF; endsequence
  sequence dwr_s; tk && busy && nib == 4'hF && plain; endsequence
  sequence bank_s; itk && opc == 8'h01; endsequence
  sequence acc_s; itk && opc == 8'h0E; endsequence
  rd_src_a: assert property (src_s |=> mem_rd && mem_addr == $past(fa))
    else $error("source read");
  wr_dst_a: assert property (src_s ##4 dwr_s |-> ##3 mem_wr && mem_addr == $past(fa, 3))
    else $error("dest write");
  wr_phase_a: assert property (mem_wr |-> phase == 4'h8)
    else $error("write phase");
  no_dummy_a: assert property (dst_s |=> !mem_rd [*3])
    else $error("dummy read");
  bank_load_a: assert property (bank_s |=> bank_selection_register == $past(kb))
    else $error("bank load");
  acc_load_a: assert property (acc_s |=> accumulator == $past(lit))
    else $error("acc load");
endmodule

// *** testbench/dmx_mem_model.sv ***
// data memory model facing the execute block
`timescale 1ns/1ps
module dmx_mem_model (
  input  logic        clock,
  input  logic [11:0] mem_addr,
  input  logic        mem_rd,
  input  logic        mem_wr,
  input  logic [7:0]  mem_wdata,
  output logic [7:0]  mem_rdata
);
  logic [7:0] mem [4096];
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(posedge clock) if (mem_wr) mem[mem_addr] <= mem_wdata;
endmodule

// *** testbench/tb.sv ***
// bench of the data-move execute block
`timescale 1ns/1ps
module tb;
  logic        clock = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, mem_rd, mem_wr, busy, bad_dest;
  logic [15:0] instr_word = 16'h0000;
  logic [11:0] mem_addr;
  logic [7:0]  mem_rdata, mem_wdata, bank_selection_register, accumulator;
  logic [3:0]  phase;
  int          errors = 0, checked = 0;
  always #12.5 clock = ~clock;
  dmx_exec i_dmx_exec (
    .clock                   (clock),
    .sys_rst                 (sys_rst),
    .instr_word              (instr_word),
    .instr_valid             (instr_valid),
    .mem_addr                (mem_addr),
    .mem_rd                  (mem_rd),
    .mem_rdata               (mem_rdata),
    .mem_wr                  (mem_wr),
    .mem_wdata               (mem_wdata),
    .bank_selection_register (bank_selection_register),
    .accumulator             (accumulator),
    .phase                   (phase),
    .busy                    (busy),
    .bad_dest                (bad_dest)
  );
  dmx_mem_model i_dmx_mem_model (
    .clock     (clock),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );
  task chk(input string n, input logic [11:0] e, s);
    checked++;
    if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
    if (s !== e) errors++;
  endtask
  task op(input logic [15:0] w);
    do @(negedge clock); while (phase !== 4'h8);
    @(posedge clock);
    instr_word <= w;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    @(negedge clock);
  endtask
  task t_lit;
    op(16'h01A7);
    chk("bank", 8'h07, bank_selection_register);
    op(16'h0E5A);
    chk("acc", 8'h5A, accumulator);
  endtask
  task t_copy;
    op(16'hC023);
    chk("busy", 12'h001, busy);
    op(16'hF045);
    repeat (3) @(negedge clock);
    chk("copy", 8'h23, i_dmx_mem_model.mem[69]);
    chk("dest addr", 12'h045, mem_addr);
    chk("wdata", 8'h23, mem_wdata);
    chk("busy", 12'h000, busy);
    chk("bad dest", 12'h000, bad_dest);
    op(16'hCFE8);
    op(16'hF046);
    repeat (3) @(negedge clock);
    chk("from acc", 8'h5A, i_dmx_mem_model.mem[70]);
    op(16'hCF30);
    op(16'hFFE8);
    repeat (3) @(negedge clock);
    chk("to acc", 8'h30, accumulator);
    chk("acc no write", 8'hE8, i_dmx_mem_model.mem[4072]);
  endtask
  task t_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    @(negedge clock);
    chk("rst acc", 8'h00, accumulator);
    chk("rst bank", 8'h00, bank_selection_register);
    chk("rst phase", 4'h1, phase);
    chk("rst busy", 12'h000, busy);
    chk("rst addr", 12'h000, mem_addr);
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
  endtask
  task results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    t_lit();
    t_copy();
    t_reset();
    t_lit();
    results();
  end
  initial begin
    #10us errors++;
    results();
  end
endmodule
bind dmx_exec dmx_exec_asserts i_dmx_exec_asserts (
  .clock                   (clock),
  .sys_rst                 (sys_rst),
  .instr_word              (instr_word),
  .instr_valid             (instr_valid),
  .mem_addr                (mem_addr),
  .mem_rd                  (mem_rd),
  .mem_wr                  (mem_wr),
  .bank_selection_register (bank_selection_register),
  .accumulator             (accumulator),
  .phase                   (phase),
  .busy                    (busy)
);
